// file: hw/arcp_pkg.sv
// Function
// - port set values taken together, never mixed
// - protection thresholds not settable through port
// - display shows port set values in remote
// - 5 V or 10 V range; reference equals full scale
// - monitors map 0-100 percent to full scale
// - set values above full scale clip to 100 percent
// - set and actual values use 26214 steps
// - inputs acquired at most 500 Hz
// - alarm in remote switches DC output off
// - configuration picks alarms reported on port
// - protection alarms acknowledged by 50 ms low pulse
// - remote-select low means remote, high/open internal
// - alarm1 high on overtemperature or power fail
// - alarm2 high on overvoltage, overcurrent, overpower
// - standby low off, high on; ack only remote
// - status low in voltage regulation, else high
// - status role: regulation mode or output state
// - one controlling interface; conflicts error or ignored
// - setup inverts standby function and levels
package arcp_pkg;

  ////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ = 32'h0098_9680; // 10 MHz
  localparam int unsigned SAMPLE_HZ = 32'h0000_01f4; // 500 Hz
  localparam int unsigned SAMPLE_CYC = (CLK_HZ + SAMPLE_HZ - 1) / SAMPLE_HZ;
  localparam int unsigned ACK_LOW_MS = 32'h0000_0032; // 50 ms
  // least low time, rounded up to whole samples
  localparam int unsigned ACK_LOW_SAMPLES = (ACK_LOW_MS * SAMPLE_HZ + 999) / 1000;

  ////////////////////////////////////////////////////////////
  // value scaling
  localparam int unsigned VAL_W = 15;
  localparam logic [14:0] FULL_CODE = 15'h6666; // 26214 steps
  localparam logic [14:0] FS_5V_MV = 15'h1388; // 5000 mV
  localparam logic [14:0] FS_10V_MV = 15'h2710; // 10000 mV
  localparam logic [1:0] PIN_RST = 2'h3; // open pins read high
  localparam logic [4:0] ACK_CNT_W_MAX = 5'h1f; // counter ceiling

  ////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [14:0] volt;
    logic [14:0] curr;
    logic [14:0] powr;
  } arcp_set_t;

  typedef struct packed {
    logic overvoltage_protection;
    logic overcurrent_protection;
    logic overpower_protection;
    logic overtemperature;
    logic power_fail;
  } arcp_alarm_t;

  typedef enum logic [1:0] {
    constant_voltage_regulation = 2'b00,
    constant_current_regulation = 2'b01,
    constant_power_regulation = 2'b10,
    constant_resistance_regulation = 2'b11
  } arcp_reg_mode_t;

  typedef enum logic [1:0] {
    ctl_manual = 2'b00,
    ctl_analog = 2'b01,
    ctl_digital = 2'b10
  } arcp_ctl_t;

  ////////////////////////////////////////////////////////////
  // functions
  function automatic logic [14:0] full_scale(input logic range_10v);
    full_scale = range_10v ? FS_10V_MV : FS_5V_MV;
  endfunction

  // millivolts to code, clipped at full scale
  function automatic logic [14:0] set_scale(input logic [14:0] mv, input logic [14:0] fs);
    logic [31:0] p;
    p = 32'(mv) * 32'(FULL_CODE);
    if (mv >= fs) begin
      set_scale = FULL_CODE;
    end else begin
      set_scale = 15'(p / 32'(fs));
    end
  endfunction

  // code to millivolts, code clipped to full code
  function automatic logic [14:0] mon_scale(input logic [14:0] code, input logic [14:0] fs);
    logic [31:0] c;
    c = (code > FULL_CODE) ? 32'(FULL_CODE) : 32'(code);
    mon_scale = 15'((c * 32'(fs)) / 32'(FULL_CODE));
  endfunction

endpackage

// file: hw/arcp_pin_sync.sv
`timescale 1ns/1ps
module arcp_pin_sync
  import arcp_pkg::*;
(
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst_n, // sync reset, low
  input wire logic i_clk_en, // freeze when low
  input wire logic i_tick, // sample-rate tick
  input wire logic [1:0] i_pin, // raw pins
  output logic [1:0] o_sampled // tick-sampled levels
);

  logic [1:0] meta_reg; // first stage, read only by second
  logic [1:0] sync_reg; // second stage

  // two-stage synchroniser, then hold until next tick
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      meta_reg <= PIN_RST;
      sync_reg <= PIN_RST;
      o_sampled <= PIN_RST;
    end else if (i_clk_en) begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
      if (i_tick) begin
        o_sampled <= sync_reg;
      end
    end
  end

endmodule

// file: hw/arcp_port.sv
`timescale 1ns/1ps
module arcp_port
  import arcp_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC // shorten in sim
)(
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst_n, // sync reset, low
  input wire logic i_clk_en, // freeze when low
  input wire logic i_remote_sel_n, // remote-select pin
  input wire logic i_output_standby_in, // standby pin
  input wire arcp_set_t i_port_set, // port set values, mV
  input wire arcp_set_t i_local_set, // knob set values, code
  input wire logic [14:0] i_actual_volt, // actual voltage code
  input wire logic [14:0] i_actual_curr, // actual current code
  input wire arcp_alarm_t i_alarms, // alarm conditions
  input wire arcp_reg_mode_t i_reg_mode, // regulation mode
  input wire logic i_ready, // start phase done
  input wire logic i_allow_remote, // remote allowed
  input wire logic i_digital_active, // digital owns control
  input wire logic i_digital_req, // digital remote request
  input wire logic i_local_on_req, // panel output request
  input wire logic i_range_10v, // 1: 10 V range
  input wire logic i_standby_invert, // invert standby pin
  input wire logic i_status_role, // 1: status shows output
  input wire arcp_alarm_t i_alarm_report, // report mask
  output arcp_set_t o_active_set, // applied set values
  output arcp_set_t o_display_set, // displayed set values
  output logic o_remote_active, // analog remote in force
  output logic [14:0] o_reference_out, // reference, mV
  output logic [14:0] o_voltage_monitor_out, // mV
  output logic [14:0] o_current_monitor_out, // mV
  output logic o_dc_output_on, // DC output state
  output logic o_alarm1, // alarm output 1
  output logic o_alarm2, // alarm output 2
  output logic o_status, // status output
  output logic o_digital_remote_err, // refused request
  output logic o_alarm_ack // one-cycle acknowledge
);

  ////////////////////////////////////////////////////////////
  // sample-rate tick
  logic [31:0] tick_cnt_reg; // cycles since last tick
  logic tick_reg; // one-cycle tick
  // counter runs free; a tick every SAMPLE_CYCLES cycles
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tick_cnt_reg <= 32'h0;
      tick_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (tick_cnt_reg >= SAMPLE_CYCLES - 1) begin
        tick_cnt_reg <= 32'h0;
        tick_reg <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
        tick_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // pin synchronisation
  logic [1:0] pins_smp; // {remote-select, standby}
  arcp_pin_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_tick(tick_reg),
    .i_pin({i_remote_sel_n, i_output_standby_in}),
    .o_sampled(pins_smp)
  );

  logic remote_req; // remote-select asks for remote
  logic standby_on; // standby asks for output on
  // low pin means remote; open pin reads high, internal
  assign remote_req = !pins_smp[1];
  // inversion swaps both function and idle level
  assign standby_on = pins_smp[0] ^ i_standby_invert;

  ////////////////////////////////////////////////////////////
  // control location
  arcp_ctl_t ctl_reg; // who controls the device
  arcp_ctl_t ctl_next; // next location
  // only one interface owns control at a time
  always_comb begin
    ctl_next = ctl_reg;
    case (ctl_reg)
      ctl_manual: begin
        if (i_digital_active) begin
          ctl_next = ctl_digital;
        end else if (remote_req && i_allow_remote) begin
          ctl_next = ctl_analog;
        end
      end
      ctl_analog: begin
        // local lock only pauses; pin still says remote
        if (!remote_req || !i_allow_remote) begin
          ctl_next = ctl_manual;
        end
      end
      ctl_digital: begin
        // remote-select changes are ignored here
        if (!i_digital_active) begin
          ctl_next = ctl_manual;
        end
      end
      default: begin
        ctl_next = ctl_manual;
      end
    endcase
  end

  logic remote_active; // analog remote in force
  assign remote_active = (ctl_reg == ctl_analog);

  // location is re-evaluated every enabled cycle; pin changes show one cycle after the tick that samples them
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctl_reg <= ctl_manual;
      o_remote_active <= 1'b0;
    end else if (i_clk_en) begin
      ctl_reg <= ctl_next;
      o_remote_active <= (ctl_next == ctl_analog);
    end
  end

  // digital takeover while analog owns control is refused
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_digital_remote_err <= 1'b0;
    end else if (i_clk_en) begin
      o_digital_remote_err <= i_digital_req && remote_active;
    end
  end

  ////////////////////////////////////////////////////////////
  // set values
  arcp_set_t port_code; // port values as codes
  arcp_set_t port_smp_reg; // port codes held per tick
  logic [14:0] fs_mv; // full scale of the range
  assign fs_mv = full_scale(i_range_10v);

  // every input clips at full scale to exactly 100 percent
  always_comb begin
    port_code.volt = set_scale(i_port_set.volt, fs_mv);
    port_code.curr = set_scale(i_port_set.curr, fs_mv);
    port_code.powr = set_scale(i_port_set.powr, fs_mv);
  end

  // the converter reads the port only once per tick
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      port_smp_reg <= '0;
    end else if (i_clk_en && tick_reg) begin
      port_smp_reg <= port_code;
    end
  end

  // all three come from one source, never a mix
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_active_set <= '0;
      o_display_set <= '0;
    end else if (i_clk_en) begin
      if (remote_active) begin
        o_active_set <= port_smp_reg;
        o_display_set <= port_smp_reg;
      end else begin
        o_active_set <= i_local_set;
        o_display_set <= i_local_set;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // reference and monitors
  // monitors track actual values every cycle; the slow
  // conversion rate is the converter's, not ours
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_reference_out <= 15'h0;
      o_voltage_monitor_out <= 15'h0;
      o_current_monitor_out <= 15'h0;
    end else if (i_clk_en) begin
      o_reference_out <= fs_mv;
      o_voltage_monitor_out <= mon_scale(i_actual_volt, fs_mv);
      o_current_monitor_out <= mon_scale(i_actual_curr, fs_mv);
    end
  end

  ////////////////////////////////////////////////////////////
  // acknowledge detection
  logic seen_on_reg; // an on level preceded the low
  logic [4:0] low_cnt_reg; // consecutive off samples
  logic ack_now; // qualified high-low-high
  // the low phase must span the least time in samples
  assign ack_now = tick_reg && standby_on && seen_on_reg
    && (32'(low_cnt_reg) >= ACK_LOW_SAMPLES) && remote_active;

  // counter saturates so a long low still qualifies
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      seen_on_reg <= 1'b0;
      low_cnt_reg <= 5'h0;
      o_alarm_ack <= 1'b0;
    end else if (i_clk_en) begin
      o_alarm_ack <= ack_now;
      if (tick_reg) begin
        if (standby_on) begin
          seen_on_reg <= 1'b1;
          low_cnt_reg <= 5'h0;
        end else if (seen_on_reg && low_cnt_reg != ACK_CNT_W_MAX) begin
          low_cnt_reg <= low_cnt_reg + 5'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // alarms
  logic [2:0] prot_latch_reg; // {ovp, ocp, opp} awaiting ack
  logic [2:0] prot_new; // protection events now
  logic [2:0] prot_next; // next latch value
  logic alarm_any; // any alarm blocks the output
  // thresholds live in the supervision logic; the port
  // has no path to them, it only reads the outcome
  assign prot_new = {i_alarms.overvoltage_protection,
    i_alarms.overcurrent_protection, i_alarms.overpower_protection};

  // a new event in the clearing cycle wins over the ack
  assign prot_next = (prot_latch_reg & ~{3{o_alarm_ack}}) | prot_new;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      prot_latch_reg <= 3'h0;
    end else if (i_clk_en) begin
      prot_latch_reg <= prot_next;
    end
  end

  assign alarm_any = (|prot_latch_reg) || (|prot_new)
    || i_alarms.overtemperature || i_alarms.power_fail;

  logic a1_src; // reportable alarm-1 causes
  logic a2_src; // reportable alarm-2 causes
  // the report mask picks which alarms reach the pins
  assign a1_src = (i_alarms.overtemperature && i_alarm_report.overtemperature)
    || (i_alarms.power_fail && i_alarm_report.power_fail);
  assign a2_src = (prot_latch_reg[2] && i_alarm_report.overvoltage_protection)
    || (prot_latch_reg[1] && i_alarm_report.overcurrent_protection)
    || (prot_latch_reg[0] && i_alarm_report.overpower_protection);

  ////////////////////////////////////////////////////////////
  // output state and status pins
  logic dc_next; // next DC output state
  // an alarm forces the output off in any location
  always_comb begin
    if (alarm_any) begin
      dc_next = 1'b0;
    end else if (remote_active) begin
      dc_next = standby_on;
    end else begin
      dc_next = i_local_on_req;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_dc_output_on <= 1'b0;
    end else if (i_clk_en) begin
      o_dc_output_on <= dc_next;
    end
  end

  // pins held low through the start phase so they at
  // least sit still while the controller ignores them
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_alarm1 <= 1'b0;
      o_alarm2 <= 1'b0;
      o_status <= 1'b0;
    end else if (i_clk_en) begin
      if (!i_ready) begin
        o_alarm1 <= 1'b0;
        o_alarm2 <= 1'b0;
        o_status <= 1'b0;
      end else begin
        o_alarm1 <= a1_src;
        o_alarm2 <= a2_src;
        if (i_status_role) begin
          o_status <= !dc_next;
        end else begin
          o_status <= (i_reg_mode != constant_voltage_regulation);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic [31:0] off_run_reg; // helper: enabled cycles of the current off run
  // measures the low phase in cycles, apart from the sample counter it judges;
  // limitation: the invert setting is taken as static while a run is counted
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || (i_clk_en && tick_reg && standby_on)) begin
      off_run_reg <= 32'h0;
    end else if (i_clk_en && !standby_on && off_run_reg != 32'hffff_ffff) begin
      off_run_reg <= off_run_reg + 32'h1;
    end
  end

  chk_tick_spacing: assert property (
    i_clk_en && tick_reg |=> !tick_reg)
    else $error("tick fired on two cycles in a row");
  chk_set_together: assert property (
    i_clk_en && remote_active |=> o_active_set == $past(port_smp_reg))
    else $error("remote set values not taken from port");
  chk_display_port: assert property (
    i_clk_en && remote_active |=> o_display_set == $past(port_smp_reg))
    else $error("display differs from port set values");
  chk_clip_full: assert property (
    port_code.volt <= FULL_CODE && port_code.curr <= FULL_CODE
    && port_code.powr <= FULL_CODE)
    else $error("set value exceeds full code");
  chk_reference_fs: assert property (
    i_clk_en |=> o_reference_out == ($past(i_range_10v) ? FS_10V_MV : FS_5V_MV))
    else $error("reference not at full scale");
  chk_alarm_off: assert property (
    i_clk_en && alarm_any |=> !o_dc_output_on)
    else $error("output on during alarm");
  chk_alarm1_pin: assert property (
    i_clk_en && i_ready |=> o_alarm1 == $past(a1_src))
    else $error("alarm1 pin wrong");
  chk_alarm2_hold: assert property (
    i_clk_en && i_ready && (|prot_latch_reg) && !o_alarm_ack && !ack_now
    && (&i_alarm_report) |=> o_alarm2)
    else $error("alarm2 dropped before acknowledge");
  chk_ack_remote: assert property (
    o_alarm_ack |-> $past(remote_active))
    else $error("acknowledge outside remote control");
  chk_ack_low_time: assert property (
    ack_now |-> off_run_reg >= ACK_LOW_SAMPLES * SAMPLE_CYCLES)
    else $error("acknowledge with too short low");
  chk_digital_refuse: assert property (
    i_clk_en && i_digital_req && remote_active |=> o_digital_remote_err)
    else $error("digital request not refused");
  chk_status_mode: assert property (
    i_clk_en && i_ready && !i_status_role
    && i_reg_mode == constant_voltage_regulation |=> !o_status)
    else $error("status high in voltage regulation");
  cov_remote_on: cover property ($rose(o_remote_active));
  cov_ack_seen: cover property (o_alarm_ack);
  cov_alarm2_set: cover property ($rose(o_alarm2));
  cov_refused: cover property (o_digital_remote_err);

endmodule

// file: verif/arcp_ctrl_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// external controller: drives the remote-select, standby and set-value pins
module arcp_ctrl_model
  import arcp_pkg::*;
(
  input wire logic i_sys_clk, // system clock
  input wire logic i_remote_req, // wish for analog remote
  input wire logic i_standby_lvl, // level wanted on standby pin
  input wire arcp_set_t i_set_mv, // set values to present, mV
  output logic o_remote_sel_n, // remote-select pin
  output logic o_standby_pin, // standby pin
  output arcp_set_t o_port_set // set-value inputs, mV
);
  logic pulse_busy; // ack pulse owns the standby pin

  // open pins read high; set inputs never float
  initial begin
    o_remote_sel_n = 1'b1;
    o_standby_pin = 1'b1;
    o_port_set = '0;
    pulse_busy = 1'b0;
  end

  // pins move just after the edge, like any slow controller output
  always @(posedge i_sys_clk) begin
    #1;
    o_remote_sel_n = !i_remote_req;
    o_port_set = i_set_mv;
    if (!pulse_busy) begin
      o_standby_pin = i_standby_lvl;
    end
  end

  // high-low-high acknowledge, low for low_cyc cycles
  task automatic ack_pulse(input int low_cyc);
    @(posedge i_sys_clk);
    #2;
    pulse_busy = 1'b1;
    o_standby_pin = 1'b1;
    repeat (16) @(posedge i_sys_clk);
    #2;
    o_standby_pin = 1'b0;
    repeat (low_cyc) @(posedge i_sys_clk);
    #2;
    o_standby_pin = 1'b1;
    pulse_busy = 1'b0;
  endtask
endmodule

// file: verif/arcp_port_tb_top.sv
`timescale 1ns/1ps
module arcp_port_tb_top
  import arcp_pkg::*;
;
  localparam int SC = 8; // short sample period keeps the ack wait small
  localparam int I_SET = 0, I_DISP = 1, I_REM = 2, I_REF = 3, I_VOLTAGE_MONITOR_OUT = 4, I_CURRENT_MONITOR_OUT = 5;
  localparam int I_DCON = 6, I_AL1 = 7, I_AL2 = 8, I_STAT = 9, I_ERR = 10, I_ACK = 11;
  typedef struct { int id; logic [44:0] exp; } arcp_note_t;
  string nm [12] = '{"active_set", "display_set", "remote_active", "reference", "voltage_monitor_out", "current_monitor_out",
    "dc_on", "alarm1", "alarm2", "status", "digital_err", "ack_count"};
  logic clk = 0, rst_n, rem_req, sb_lvl, ready, dig_act, dig_req, local_on, rng, inv, role, allow;
  logic sel_n, sb_pin, rem, dc_on, al1, al2, stat, err, ack;
  arcp_set_t set_mv, port_set, local_set, act_set, disp_set;
  arcp_alarm_t alarms, report;
  arcp_reg_mode_t mode;
  logic [14:0] act_v, act_c, ref_mv, voltage_monitor_out, current_monitor_out;
  int n_fail = 0, compares = 0, n_ack = 0, fs, av, ac;
  int mv [3];
  arcp_note_t q [$], cur;
  event look;

  always #50 clk = ~clk;

  arcp_ctrl_model i_ctrl (.i_sys_clk(clk), .i_remote_req(rem_req), .i_standby_lvl(sb_lvl),
    .i_set_mv(set_mv), .o_remote_sel_n(sel_n), .o_standby_pin(sb_pin), .o_port_set(port_set));

  arcp_port #(.SAMPLE_CYCLES(SC)) i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_remote_sel_n(sel_n), .i_output_standby_in(sb_pin), .i_port_set(port_set),
    .i_local_set(local_set), .i_actual_volt(act_v), .i_actual_curr(act_c), .i_alarms(alarms),
    .i_reg_mode(mode), .i_ready(ready), .i_allow_remote(allow), .i_digital_active(dig_act),
    .i_digital_req(dig_req), .i_local_on_req(local_on), .i_range_10v(rng),
    .i_standby_invert(inv), .i_status_role(role), .i_alarm_report(report),
    .o_active_set(act_set), .o_display_set(disp_set), .o_remote_active(rem),
    .o_reference_out(ref_mv), .o_voltage_monitor_out(voltage_monitor_out), .o_current_monitor_out(current_monitor_out),
    .o_dc_output_on(dc_on), .o_alarm1(al1), .o_alarm2(al2), .o_status(stat),
    .o_digital_remote_err(err), .o_alarm_ack(ack));

  // acknowledge is a one-cycle pulse, so count it where it shows
  always @(posedge clk) if (ack === 1'b1) n_ack <= n_ack + 1;

  ////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [14:0] to_code(input int v, input int f);
    to_code = (v >= f) ? FULL_CODE : 15'(v * int'(FULL_CODE) / f);
  endfunction

  function automatic logic [14:0] to_mv(input int c, input int f);
    to_mv = 15'(((c > int'(FULL_CODE)) ? int'(FULL_CODE) : c) * f / int'(FULL_CODE));
  endfunction

  function automatic logic [44:0] seen(input int id);
    case (id)
      I_SET: seen = act_set;
      I_DISP: seen = disp_set;
      I_REM: seen = 45'(rem);
      I_REF: seen = 45'(ref_mv);
      I_VOLTAGE_MONITOR_OUT: seen = 45'(voltage_monitor_out);
      I_CURRENT_MONITOR_OUT: seen = 45'(current_monitor_out);
      I_DCON: seen = 45'(dc_on);
      I_AL1: seen = 45'(al1);
      I_AL2: seen = 45'(al2);
      I_STAT: seen = 45'(stat);
      I_ERR: seen = 45'(err);
      default: seen = 45'(n_ack);
    endcase
  endfunction

  task automatic check(input string name, input logic [44:0] got, input logic [44:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // the driver notes what it expects; the watcher compares at once
  task automatic note(input int id, input logic [44:0] exp);
    q.push_back('{id, exp});
    -> look;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // bounded wait: pin changes take up to one tick plus sync delay
  task automatic wait_rem(input logic v);
    int k;
    k = 0;
    while (rem !== v && k < 4 * SC) begin
      step(1);
      k++;
    end
  endtask

  task automatic summarize();
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // watcher and watchdog
  initial begin
    forever begin
      @(look);
      while (q.size() > 0) begin
        cur = q.pop_front();
        check(nm[cur.id], seen(cur.id), cur.exp);
      end
    end
  end

  initial begin
    repeat (8000) @(posedge clk);
    n_fail++;
    summarize();
  end

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h2634));
    {rst_n, rem_req, dig_act, dig_req, local_on, rng, inv, role} = '0;
    {sb_lvl, ready, allow} = 3'h7;
    {set_mv, local_set, act_v, act_c, alarms} = '0;
    report = '1;
    mode = constant_voltage_regulation;
    step(12);
    note(I_REM, 0);
    note(I_DCON, 0);
    rst_n = 1'b1;
    // manual: knob values and panel request rule
    local_set = {15'($urandom_range(26214, 0)), 15'($urandom_range(26214, 0)), 15'h6666};
    local_on = 1'b1;
    step(3);
    note(I_SET, local_set);
    note(I_DCON, 1);
    note(I_REF, FS_5V_MV);
    rem_req = 1'b1;
    wait_rem(1'b1);
    note(I_REM, 1);
    // both ranges, in-range and excess set values
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 2; k++) begin
        rng = r[0];
        fs = r ? int'(FS_10V_MV) : int'(FS_5V_MV);
        foreach (mv[i]) mv[i] = k ? fs + $urandom_range(3000, 1) : $urandom_range(fs, 0);
        set_mv = {15'(mv[0]), 15'(mv[1]), 15'(mv[2])};
        av = $urandom_range(26300, 0);
        ac = $urandom_range(26300, 0);
        act_v = 15'(av);
        act_c = 15'(ac);
        step(3 * SC);
        note(I_SET, {to_code(mv[0], fs), to_code(mv[1], fs), to_code(mv[2], fs)});
        note(I_DISP, {to_code(mv[0], fs), to_code(mv[1], fs), to_code(mv[2], fs)});
        note(I_REF, 15'(fs));
        note(I_VOLTAGE_MONITOR_OUT, to_mv(av, fs));
        note(I_CURRENT_MONITOR_OUT, to_mv(ac, fs));
      end
    end
    note(I_DCON, 1);
    // digital request refused while analog owns control
    dig_req = 1'b1;
    step(1);
    note(I_ERR, 1);
    dig_req = 1'b0;
    step(1);
    note(I_ERR, 0);
    // status output in both roles
    for (int m = 0; m < 4; m++) begin
      mode = arcp_reg_mode_t'(m);
      step(3);
      note(I_STAT, m != 0);
    end
    role = 1'b1;
    step(3);
    note(I_STAT, 0);
    inv = 1'b1;
    step(3 * SC);
    note(I_DCON, 0);
    note(I_STAT, 1);
    inv = 1'b0;
    step(3 * SC);
    // alarm pins, report mask, start phase
    alarms.overtemperature = 1'b1;
    step(3);
    note(I_AL1, 1);
    note(I_DCON, 0);
    report.overtemperature = 1'b0;
    step(3);
    note(I_AL1, 0);
    report = '1;
    ready = 1'b0;
    step(3);
    note(I_AL1, 0);
    ready = 1'b1;
    alarms.overtemperature = 1'b0;
    alarms.power_fail = 1'b1;
    step(3);
    note(I_AL1, 1);
    alarms.power_fail = 1'b0;
    alarms.overvoltage_protection = 1'b1;
    step(1);
    alarms.overvoltage_protection = 1'b0;
    step(3 * SC);
    note(I_AL2, 1);
    note(I_DCON, 0);
    // a low pulse shorter than 50 ms is no acknowledge
    i_ctrl.ack_pulse(20 * SC);
    step(3 * SC);
    note(I_ACK, 0);
    note(I_AL2, 1);
    i_ctrl.ack_pulse(27 * SC);
    step(3 * SC);
    note(I_ACK, 1);
    note(I_AL2, 0);
    note(I_DCON, 1);
    // locking remote out drops analog control; unlocking resumes it
    allow = 1'b0;
    step(2);
    note(I_REM, 0);
    allow = 1'b1;
    wait_rem(1'b1);
    note(I_REM, 1);
    // remote-select ignored while digital control holds the device
    rem_req = 1'b0;
    wait_rem(1'b0);
    note(I_REM, 0);
    dig_act = 1'b1;
    rem_req = 1'b1;
    step(3 * SC);
    note(I_REM, 0);
    step(2);
    summarize();
  end
endmodule
